// ==== design/tccp_defs.vh ====
`ifndef TCCP_DEFS_VH
`define TCCP_DEFS_VH

// Register byte offsets
`define TCCP_CTRL_OFS 8'h00
`define TCCP_CMD_OFS 8'h04
`define TCCP_STATUS_OFS 8'h08
`define TCCP_FLAG_OFS 8'h0c
`define TCCP_CNT_OFS 8'h10
`define TCCP_TOP_OFS 8'h14
// Channel slots: channel x at (x + 2) * 16, word index inside the slot
`define TCCP_CH_SLOT0 4'h2
`define TCCP_CH_CTRL_IDX 2'h0
`define TCCP_CH_CCV_IDX 2'h1
`define TCCP_CH_PEEK_IDX 2'h2
`define TCCP_CH_BUF_IDX 2'h3

// Global control fields
`define TCCP_CTRL_MODE_LSB 0
`define TCCP_CTRL_QDM_BIT 2
`define TCCP_CTRL_X2_BIT 3
`define TCCP_CTRL_ATI_BIT 4
`define TCCP_CTRL_RSS_BIT 5
`define TCCP_CTRL_RESET 6'h00
// Command bits
`define TCCP_CMD_START_BIT 0
`define TCCP_CMD_STOP_BIT 1
`define TCCP_CMD_RELOAD_BIT 2
// Counter modes
`define TCCP_CNT_UP 2'h0
`define TCCP_CNT_DOWN 2'h1
`define TCCP_CNT_UPDOWN 2'h2
`define TCCP_CNT_QUAD 2'h3
`define TCCP_TOP_RESET 16'hffff

// Channel control fields
`define TCCP_CH_MODE_LSB 0
`define TCCP_CH_INIT_BIT 2
`define TCCP_CH_INV_BIT 4
`define TCCP_CH_MACT_LSB 8
`define TCCP_CH_OACT_LSB 10
`define TCCP_CH_UACT_LSB 12
`define TCCP_CH_INPUT_SOURCE_SELECT_BIT 16
`define TCCP_CH_EVSEL_LSB 18
`define TCCP_CH_FILT_BIT 20
`define TCCP_CH_EDGE_LSB 24
`define TCCP_CH_CTRL_RESET 26'h0000000
// Channel modes
`define TCCP_MODE_OFF 2'h0
`define TCCP_MODE_CAPT 2'h1
`define TCCP_MODE_CMP 2'h2
`define TCCP_MODE_PWM 2'h3
// Output actions
`define TCCP_ACT_NONE 2'h0
`define TCCP_ACT_TOGGLE 2'h1
`define TCCP_ACT_CLEAR 2'h2
`define TCCP_ACT_SET 2'h3
// Capture edge select
`define TCCP_EDGE_RISE 2'h0
`define TCCP_EDGE_FALL 2'h1
`define TCCP_EDGE_BOTH 2'h2

// Status and flag fields
`define TCCP_ST_PEND_LSB 8
`define TCCP_ST_VALID_LSB 16
`define TCCP_ST_POL_LSB 24
`define TCCP_FLAG_OVF_LSB 0
`define TCCP_FLAG_CAP_LSB 4

// Input filter stability length in clock cycles
`define TCCP_FILT_CYCLES 5

`endif

// ==== design/tccp_in_filter.v ====
`timescale 1ns/1ps
`default_nettype none
`include "tccp_defs.vh"

module tccp_in_filter (
  input wire pclk,
  input wire presetn,
  input wire raw_in,
  input wire filt_en,
  output reg level_out
);
  reg sync1_reg;
  reg sync2_reg;
  reg hist_reg;
  reg [2:0] run_reg;
  localparam integer FILT_LEN = `TCCP_FILT_CYCLES;
  localparam [2:0] RUN_LAST = FILT_LEN[2:0] - 3'd1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      hist_reg <= 1'b0;
      run_reg <= 3'h0;
      level_out <= 1'b0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      hist_reg <= sync2_reg;
      if (sync2_reg != hist_reg)
        run_reg <= 3'h0;
      else if (run_reg != RUN_LAST)
        run_reg <= run_reg + 3'h1;
      if (!filt_en)
        level_out <= sync2_reg;
      else if (run_reg == RUN_LAST)
        level_out <= hist_reg;
    end
  end
endmodule
`default_nettype wire

// ==== design/tccp_quad_dec.v ====
`timescale 1ns/1ps
`default_nettype none

module tccp_quad_dec (
  input wire pclk,
  input wire presetn,
  input wire chan_a,
  input wire chan_b,
  input wire x4_mode,
  output wire step,
  output wire count_up
);
  reg a_d_reg;
  reg b_d_reg;
  wire a_edge;
  wire b_edge;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_d_reg <= 1'b0;
      b_d_reg <= 1'b0;
    end else begin
      a_d_reg <= chan_a;
      b_d_reg <= chan_b;
    end
  end

  assign a_edge = chan_a ^ a_d_reg;
  assign b_edge = chan_b ^ b_d_reg;
  // Simultaneous edges on both channels are illegal and do not count
  assign step = a_edge ? ~b_edge : (x4_mode & b_edge);
  // A edge: up when new A differs from B; B edge: up when new B equals A
  assign count_up = a_edge ? (chan_a ^ chan_b) : ~(chan_a ^ chan_b);
endmodule
`default_nettype wire

// ==== design/tccp_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "tccp_defs.vh"

module tccp_top #(
  parameter CW = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [2:0] cc_pin_in,
  input wire [3:0] evt_in,
  output wire [2:0] cc_out
);
  reg [5:0] ctrl_reg;
  reg [CW-1:0] cnt_reg;
  reg [CW-1:0] top_reg;
  reg dir_reg;
  reg running_reg;
  reg [6:0] flag_reg;
  reg [CW-1:0] cnt_next;
  reg dir_next;
  reg ovf;
  reg udf;
  reg [31:0] rd_data;
  reg rd_err;

  wire [1:0] cmode = ctrl_reg[`TCCP_CTRL_MODE_LSB +: 2];
  wire x2 = ctrl_reg[`TCCP_CTRL_X2_BIT];
  wire always_track_input = ctrl_reg[`TCCP_CTRL_ATI_BIT];
  wire rss = ctrl_reg[`TCCP_CTRL_RSS_BIT];
  wire [CW-1:0] step_sz = x2 ? {{(CW-2){1'b0}}, 2'h2} : {{(CW-1){1'b0}}, 1'b1};
  wire [CW-1:0] top_eff = x2 ? {top_reg[CW-1:1], 1'b0} : top_reg;
  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire [1:0] ch_idx = paddr[3:2];
  wire qd_step;
  wire qd_up;
  wire step_en;
  wire reload_cmd = wr_acc & (paddr == `TCCP_CMD_OFS) & pwdata[`TCCP_CMD_RELOAD_BIT];
  wire upd_evt;
  wire zero_cross;
  wire [2:0] ch_level;
  wire [2:0] cap_valid;
  wire [2:0] pend;
  wire [2:0] pol;
  wire [2:0] ovf_set;
  wire [2:0] cap_set;
  wire [3*26-1:0] chctl_all;
  wire [3*CW-1:0] ccv_all;
  wire [3*CW-1:0] compare_capture_buffer_all;

  assign pready = 1'b1;
  assign pslverr = psel & penable & rd_err;

  tccp_quad_dec u_quad (
    .pclk(pclk),
    .presetn(presetn),
    .chan_a(ch_level[0]),
    .chan_b(ch_level[1]),
    .x4_mode(ctrl_reg[`TCCP_CTRL_QDM_BIT]),
    .step(qd_step),
    .count_up(qd_up)
  );

  assign step_en = running_reg & ((cmode != `TCCP_CNT_QUAD) | qd_step);
  assign upd_evt = (cmode == `TCCP_CNT_UP) ? ovf :
                   (cmode == `TCCP_CNT_QUAD) ? (ovf | udf) : udf;
  assign zero_cross = step_en & (cnt_reg == {CW{1'b0}}) & (cnt_next != {CW{1'b0}}) &
                      ((cmode == `TCCP_CNT_UP) | (cmode == `TCCP_CNT_UPDOWN));

  // Next counter value and wrap events
  always @* begin
    cnt_next = cnt_reg;
    dir_next = dir_reg;
    ovf = 1'b0;
    udf = 1'b0;
    if (step_en) begin
      case (cmode)
        `TCCP_CNT_UP: begin
          dir_next = 1'b1;
          if (cnt_reg >= top_eff) begin
            cnt_next = {CW{1'b0}};
            ovf = 1'b1;
          end else
            cnt_next = cnt_reg + step_sz;
        end
        `TCCP_CNT_DOWN: begin
          dir_next = 1'b0;
          if (cnt_reg < step_sz) begin
            cnt_next = top_eff;
            udf = 1'b1;
          end else
            cnt_next = cnt_reg - step_sz;
        end
        `TCCP_CNT_UPDOWN: begin
          if (dir_reg) begin
            if (cnt_reg >= top_eff) begin
              cnt_next = top_eff - step_sz;
              dir_next = 1'b0;
              ovf = 1'b1;
            end else
              cnt_next = cnt_reg + step_sz;
          end else begin
            if (cnt_reg < step_sz) begin
              cnt_next = step_sz;
              dir_next = 1'b1;
              udf = 1'b1;
            end else
              cnt_next = cnt_reg - step_sz;
          end
        end
        default: begin
          dir_next = qd_up;
          if (qd_up) begin
            if (cnt_reg >= top_reg) begin
              cnt_next = {CW{1'b0}};
              ovf = 1'b1;
            end else
              cnt_next = cnt_reg + {{(CW-1){1'b0}}, 1'b1};
          end else begin
            if (cnt_reg == {CW{1'b0}}) begin
              cnt_next = top_reg;
              udf = 1'b1;
            end else
              cnt_next = cnt_reg - {{(CW-1){1'b0}}, 1'b1};
          end
        end
      endcase
    end
  end

  // Counter, control and flag registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `TCCP_CTRL_RESET;
      cnt_reg <= {CW{1'b0}};
      top_reg <= `TCCP_TOP_RESET;
      dir_reg <= 1'b1;
      running_reg <= 1'b0;
      flag_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_next;
      dir_reg <= dir_next;
      if (wr_acc && paddr == `TCCP_CTRL_OFS)
        ctrl_reg <= pwdata[5:0];
      if (wr_acc && paddr == `TCCP_TOP_OFS)
        top_reg <= pwdata[CW-1:0];
      if (wr_acc && paddr == `TCCP_CNT_OFS) begin
        cnt_reg <= pwdata[CW-1:0];
        if (cmode == `TCCP_CNT_UPDOWN)
          dir_reg <= 1'b1;
      end
      if (wr_acc && paddr == `TCCP_CMD_OFS) begin
        if (pwdata[`TCCP_CMD_START_BIT] | pwdata[`TCCP_CMD_RELOAD_BIT])
          running_reg <= 1'b1;
        else if (pwdata[`TCCP_CMD_STOP_BIT])
          running_reg <= 1'b0;
        if (pwdata[`TCCP_CMD_RELOAD_BIT]) begin
          cnt_reg <= (cmode == `TCCP_CNT_DOWN) ? top_reg : {CW{1'b0}};
          dir_reg <= (cmode != `TCCP_CNT_DOWN);
        end
      end
      // Write one to clear; a new event in the same cycle wins
      if (wr_acc && paddr == `TCCP_FLAG_OFS)
        flag_reg <= (flag_reg & ~pwdata[6:0]) | {cap_set, 1'b0, ovf_set};
      else
        flag_reg <= flag_reg | {cap_set, 1'b0, ovf_set};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ch
      reg [25:0] chctl_reg;
      reg [CW-1:0] ccv_reg;
      reg [CW-1:0] compare_capture_buffer_reg;
      reg v0_reg;
      reg v1_reg;
      reg pol_reg;
      reg polb_reg;
      reg pend_reg;
      reg out_reg;
      reg pin_reg;
      reg lvl_d_reg;
      reg [1:0] act;
      wire [1:0] mode = chctl_reg[`TCCP_CH_MODE_LSB +: 2];
      wire [1:0] edge_sel = chctl_reg[`TCCP_CH_EDGE_LSB +: 2];
      wire [1:0] ev_sel = chctl_reg[`TCCP_CH_EVSEL_LSB +: 2];
      wire src_raw = chctl_reg[`TCCP_CH_INPUT_SOURCE_SELECT_BIT] ? evt_in[ev_sel] : cc_pin_in[g];
      wire hit = psel & penable & (paddr[7:4] == `TCCP_CH_SLOT0 + g) & (paddr[1:0] == 2'h0);
      wire rise = ch_level[g] & ~lvl_d_reg;
      wire fall = ~ch_level[g] & lvl_d_reg;
      wire cap = (mode == `TCCP_MODE_CAPT) &
                 (((edge_sel == `TCCP_EDGE_RISE) | (edge_sel == `TCCP_EDGE_BOTH)) & rise |
                  ((edge_sel == `TCCP_EDGE_FALL) | (edge_sel == `TCCP_EDGE_BOTH)) & fall);
      wire pop = hit & ~pwrite & (ch_idx == `TCCP_CH_CCV_IDX) & (mode == `TCCP_MODE_CAPT);
      wire wr_ccv = hit & pwrite & (ch_idx == `TCCP_CH_CCV_IDX);
      wire wr_buf = hit & pwrite & (ch_idx == `TCCP_CH_BUF_IDX);
      wire out_mode = (mode == `TCCP_MODE_CMP) | (mode == `TCCP_MODE_PWM);
      wire [CW-1:0] cmp_eff = x2 ? {ccv_reg[CW-1:1], 1'b0} : ccv_reg;
      wire match = out_mode & step_en & (cnt_next == cmp_eff);
      wire xfer = pend_reg & ((compare_capture_buffer_reg == {CW{1'b0}}) ? zero_cross : upd_evt);
      wire pwm_ok = (cmode == `TCCP_CNT_UP) | (cmode == `TCCP_CNT_UPDOWN);

      tccp_in_filter u_filt (
        .pclk(pclk),
        .presetn(presetn),
        .raw_in(src_raw),
        .filt_en(chctl_reg[`TCCP_CH_FILT_BIT]),
        .level_out(ch_level[g])
      );

      assign cap_valid[g] = v0_reg;
      assign pend[g] = pend_reg;
      assign pol[g] = pol_reg;
      assign ovf_set[g] = running_reg & cap & v0_reg & v1_reg & ~pop;
      assign cap_set[g] = running_reg & cap;
      assign chctl_all[g*26 +: 26] = chctl_reg;
      assign ccv_all[g*CW +: CW] = ccv_reg;
      assign compare_capture_buffer_all[g*CW +: CW] = compare_capture_buffer_reg;
      assign cc_out[g] = pin_reg;

      // Compare event action, match first
      always @* begin
        act = `TCCP_ACT_NONE;
        if (match)
          act = chctl_reg[`TCCP_CH_MACT_LSB +: 2];
        else if (ovf)
          act = chctl_reg[`TCCP_CH_OACT_LSB +: 2];
        else if (udf)
          act = chctl_reg[`TCCP_CH_UACT_LSB +: 2];
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chctl_reg <= `TCCP_CH_CTRL_RESET;
          ccv_reg <= {CW{1'b0}};
          compare_capture_buffer_reg <= {CW{1'b0}};
          v0_reg <= 1'b0;
          v1_reg <= 1'b0;
          pol_reg <= 1'b0;
          polb_reg <= 1'b0;
          pend_reg <= 1'b0;
          out_reg <= 1'b0;
          pin_reg <= 1'b0;
          lvl_d_reg <= 1'b0;
        end else begin
          lvl_d_reg <= ch_level[g];
          pin_reg <= out_reg ^ chctl_reg[`TCCP_CH_INV_BIT];
          if (hit && pwrite && ch_idx == `TCCP_CH_CTRL_IDX)
            chctl_reg <= pwdata[25:0];
          if (mode == `TCCP_MODE_CAPT) begin
            pend_reg <= 1'b0;
            // Two-entry FIFO; value register is read-only here
            if (pop && cap) begin
              if (v1_reg) begin
                ccv_reg <= compare_capture_buffer_reg;
                pol_reg <= polb_reg;
                compare_capture_buffer_reg <= cnt_reg;
                polb_reg <= rise;
              end else begin
                ccv_reg <= cnt_reg;
                pol_reg <= rise;
                v0_reg <= 1'b1;
              end
            end else if (pop) begin
              if (v1_reg) begin
                ccv_reg <= compare_capture_buffer_reg;
                pol_reg <= polb_reg;
                v1_reg <= 1'b0;
              end else
                v0_reg <= 1'b0;
            end else if (cap) begin
              if (!v0_reg) begin
                ccv_reg <= cnt_reg;
                pol_reg <= rise;
                v0_reg <= 1'b1;
              end else begin
                compare_capture_buffer_reg <= cnt_reg;
                polb_reg <= rise;
                v1_reg <= 1'b1;
              end
            end
            if (always_track_input)
              pol_reg <= ch_level[g];
          end else begin
            v0_reg <= 1'b0;
            v1_reg <= 1'b0;
            if (wr_ccv && mode == `TCCP_MODE_CMP)
              ccv_reg <= pwdata[CW-1:0];
            else if (xfer)
              ccv_reg <= compare_capture_buffer_reg;
            if (out_mode && (wr_buf || (wr_ccv && mode == `TCCP_MODE_PWM))) begin
              compare_capture_buffer_reg <= pwdata[CW-1:0];
              pend_reg <= 1'b1;
            end else if (xfer || !out_mode)
              pend_reg <= 1'b0;
            if (always_track_input || match)
              pol_reg <= ch_level[g];
          end
          // Output state
          if (mode == `TCCP_MODE_OFF)
            out_reg <= chctl_reg[`TCCP_CH_INIT_BIT];
          else if (reload_cmd && rss)
            out_reg <= chctl_reg[`TCCP_CH_INIT_BIT];
          else if (mode == `TCCP_MODE_CMP) begin
            case (act)
              `TCCP_ACT_TOGGLE: out_reg <= ~out_reg;
              `TCCP_ACT_CLEAR: out_reg <= 1'b0;
              `TCCP_ACT_SET: out_reg <= 1'b1;
              default: out_reg <= out_reg;
            endcase
          end else if (mode == `TCCP_MODE_PWM && pwm_ok && step_en)
            out_reg <= (cnt_next < cmp_eff);
        end
      end
    end
  endgenerate

  // Read mux and decode of unmapped addresses
  always @* begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    if (paddr[7:4] >= `TCCP_CH_SLOT0 && paddr[7:4] < `TCCP_CH_SLOT0 + 4'h3) begin
      case (ch_idx)
        `TCCP_CH_CTRL_IDX: rd_data = {6'h00, chctl_all[(paddr[7:4]-4'h2)*26 +: 26]};
        `TCCP_CH_BUF_IDX: rd_data = {{(32-CW){1'b0}},
                                     compare_capture_buffer_all[(paddr[7:4]-4'h2)*CW +: CW]};
        default: rd_data = {{(32-CW){1'b0}},
                            ccv_all[(paddr[7:4]-4'h2)*CW +: CW]};
      endcase
      rd_err = paddr[1:0] != 2'h0;
    end else begin
      case (paddr)
        `TCCP_CTRL_OFS: rd_data = {26'h0000000, ctrl_reg};
        `TCCP_CMD_OFS: rd_data = 32'h00000000;
        `TCCP_STATUS_OFS: rd_data = {5'h00, pol, 5'h00, cap_valid, 5'h00, pend,
                                     6'h00, dir_reg, running_reg};
        `TCCP_FLAG_OFS: rd_data = {25'h0000000, flag_reg};
        `TCCP_CNT_OFS: rd_data = {{(32-CW){1'b0}}, cnt_reg};
        `TCCP_TOP_OFS: rd_data = {{(32-CW){1'b0}}, top_reg};
        default: rd_err = 1'b1;
      endcase
    end
  end

  // Read data latched in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_data;
  end
endmodule
`default_nettype wire

// ==== tb/tccp_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module tccp_checker #(
  parameter CW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] cc_pin_in,
  input wire logic [3:0] evt_in,
  input wire logic [2:0] cc_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_setup(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence access;
    psel && penable;
  endsequence
  ready_always_a: assert property (pready) else $error("pready low");
  err_in_access_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  err_gap_a: assert property (psel && penable && paddr == 8'h18 |-> pslverr)
    else $error("no pslverr at gap");
  err_chan3_a: assert property (psel && penable && paddr == 8'h50 |-> pslverr)
    else $error("no pslverr past last channel");
  err_align_a: assert property (psel && penable && paddr == 8'h21 |-> pslverr)
    else $error("no pslverr on misaligned");
  err_mapped_a: assert property (psel && penable && (paddr == 8'h14 || paddr == 8'h40) |-> !pslverr)
    else $error("pslverr on mapped");
  rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved without read");
  cmd_zero_a: assert property (rd_setup(8'h04) |=> prdata == 32'h0) else $error("cmd read not 0");
  gap_zero_a: assert property (rd_setup(8'h18) |=> prdata == 32'h0) else $error("gap read not 0");
  cnt_width_a: assert property (rd_setup(8'h10) |=> prdata[31:CW] == '0) else $error("cnt high bits");
  status_pad_a: assert property (rd_setup(8'h08) ##1 access |-> prdata[31:27] == 5'h00 && !pslverr)
    else $error("status pad bits");
endmodule
bind tccp_top tccp_checker #(.CW(CW)) tccp_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cc_pin_in(cc_pin_in), .evt_in(evt_in), .cc_out(cc_out));
`default_nettype wire

// ==== tb/tccp_enc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tccp_enc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fwd,
  input wire logic back,
  output wire logic [1:0] ab
);
  logic [1:0] idx_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      idx_reg <= 2'h0;
    else if (fwd)
      idx_reg <= idx_reg + 2'h1;
    else if (back)
      idx_reg <= idx_reg - 2'h1;
  end
  // Gray order: one phase moves per step, A leads B going forward
  assign ab = {idx_reg[1], idx_reg[1] ^ idx_reg[0]};
endmodule
`default_nettype wire

// ==== tb/tccp_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tccp_top_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, b3;
  logic pready, pslverr, e, pin2 = 0, fwd = 0, back = 0;
  logic [3:0] evt = 4'h0;
  logic [1:0] ab;
  logic [2:0] cc_out;
  int err_count = 0, checked = 0, cycles = 0, tog, hi;
  localparam logic [31:0] CMPC [3] = '{32'h0102, 32'h0b02, 32'h0402};
  localparam int CMPV [3] = '{5, 0, 5}, CMPT [3] = '{10, 0, 10}, CMPH [3] = '{50, 100, 50};
  localparam int PG [5] = '{0, 0, 0, 2, 8}, PV [5] = '{3, 10, 0, 3, 4}, PH [5] = '{27, 90, 0, 25, 36};
  localparam logic [7:0] GAP [3] = '{8'h18, 8'h50, 8'h21};
  tccp_top tccp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cc_pin_in({pin2, ab}), .evt_in(evt), .cc_out(cc_out));
  tccp_enc_model tccp_enc_model_i (.pclk(pclk), .presetn(presetn), .fwd(fwd), .back(back), .ab(ab));
  initial forever #4 pclk = ~pclk;
  task test_done;
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      test_done();
    end
  end
  task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task step(input logic f);
    @(posedge pclk);
    fwd <= f;
    back <= !f;
    @(posedge pclk);
    fwd <= 0;
    back <= 0;
    cyc(10);
  endtask
  task pin(input logic v, input int n);
    @(posedge pclk);
    pin2 <= v;
    cyc(n);
  endtask
  task measure(input int ch, input int n);
    logic p;
    tog = 0;
    hi = 0;
    @(posedge pclk) #1 p = cc_out[ch];
    repeat (n) begin
      @(posedge pclk) #1;
      if (cc_out[ch] !== p)
        tog++;
      p = cc_out[ch];
      if (p === 1'b1)
        hi++;
    end
  endtask
  initial begin
    cyc(20);
    presetn <= 1;
    rd(8'h14);
    chk("top reset", 32'hffff, q);
    rd(8'h00);
    chk("ctrl reset", 32'h0, q);
    foreach (GAP[i]) begin
      rd(GAP[i]);
      chk("gap err", 32'h1, 32'(e));
      chk("gap data", 32'h0, q);
    end
    rd(8'h04);
    chk("cmd read", 32'h0, q);
    wr(8'h00, 32'h3);
    wr(8'h10, 32'd100);
    wr(8'h04, 32'h1);
    repeat (4) step(1'b1);
    rd(8'h10);
    chk("x2 count", 32'd102, q);
    wr(8'h00, 32'h7);
    repeat (4) step(1'b1);
    repeat (2) step(1'b0);
    rd(8'h10);
    chk("x4 count", 32'd104, q);
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h0);
    wr(8'h40, 32'h0010_0001);
    wr(8'h10, 32'h11);
    pin(1'b1, 3);
    pin(1'b0, 20);
    rd(8'h08);
    chk("glitch", 32'h0, q & 32'h0004_0000);
    pin(1'b1, 20);
    rd(8'h08);
    chk("valid pol", 32'h0404_0000, q & 32'h0404_0000);
    wr(8'h44, 32'h99);
    rd(8'h48);
    chk("peek", 32'h11, q);
    pin(1'b0, 20);
    wr(8'h10, 32'h22);
    pin(1'b1, 20);
    pin(1'b0, 20);
    rd(8'h0c);
    chk("flags stopped", 32'h0, q);
    rd(8'h4c);
    chk("buffer", 32'h22, q);
    rd(8'h48);
    chk("peek again", 32'h11, q);
    wr(8'h04, 32'h1);
    pin(1'b1, 20);
    wr(8'h04, 32'h2);
    rd(8'h0c);
    chk("overflow", 32'h4, q & 32'h4);
    rd(8'h4c);
    b3 = q;
    chk("overwrite", 32'h2b, b3);
    rd(8'h44);
    chk("pop first", 32'h11, q);
    rd(8'h44);
    chk("pop second", b3, q);
    rd(8'h08);
    chk("empty", 32'h0, q & 32'h0004_0000);
    wr(8'h40, 32'h0205_0000);
    cyc(8);
    wr(8'h10, 32'h33);
    wr(8'h40, 32'h0205_0001);
    @(posedge pclk) evt <= 4'h2;
    cyc(10);
    rd(8'h48);
    chk("event capture", 32'h33, q);
    @(posedge pclk) evt <= 4'h0;
    cyc(10);
    rd(8'h44);
    rd(8'h08);
    chk("fall pol", 32'h0004_0000, q & 32'h0404_0000);
    wr(8'h14, 32'd9);
    wr(8'h20, 32'h4);
    cyc(3);
    #1 chk("init level", 32'h1, 32'(cc_out[0]));
    wr(8'h20, 32'h14);
    cyc(3);
    #1 chk("inverted", 32'h0, 32'(cc_out[0]));
    for (int i = 0; i < 3; i++) begin
      wr(8'h04, 32'h2);
      wr(8'h20, 32'h0);
      wr(8'h10, 32'h0);
      wr(8'h20, CMPC[i]);
      wr(8'h24, CMPV[i]);
      wr(8'h04, 32'h1);
      cyc(40);
      measure(0, 100);
      chk("cmp toggles", CMPT[i], tog);
      chk("cmp high", CMPH[i], hi);
      rd(8'h08);
      chk("match pol", 32'h0100_0000, q & 32'h0100_0000);
    end
    wr(8'h00, 32'h20);
    wr(8'h04, 32'h4);
    cyc(1);
    #1 chk("reload init", 32'h0, 32'(cc_out[0]));
    cyc(12);
    #1 chk("ovf toggle", 32'h1, 32'(cc_out[0]));
    wr(8'h04, 32'h4);
    cyc(1);
    #1 chk("reload again", 32'h0, 32'(cc_out[0]));
    for (int i = 0; i < 5; i++) begin
      wr(8'h04, 32'h2);
      wr(8'h00, PG[i]);
      wr(8'h10, 32'h0);
      wr(8'h30, 32'h0);
      wr(8'h30, 32'h0103);
      wr(8'h3c, PV[i]);
      rd(8'h08);
      chk("pending", 32'h200, q & 32'h200);
      wr(8'h04, 32'h1);
      cyc(40);
      measure(1, 90);
      chk("pwm high", PH[i], hi);
      rd(8'h08);
      chk("transferred", 32'h0, q & 32'h200);
    end
    test_done();
  end
endmodule
`default_nettype wire
